// *** hdl/alt_consts.svh ***
`ifndef ALT_CONSTS_SVH
`define ALT_CONSTS_SVH
`define ALT_NUM_CH 5
`define ALT_FIELD_W 14
`define ALT_FIELD_LSB 2
`define ALT_OFF_CH0_LOW 8'h92
`define ALT_OFF_CH0_HIGH 8'h94
`define ALT_OFF_CH1_LOW 8'h96
`define ALT_OFF_CH1_HIGH 8'h98
`define ALT_OFF_CH2_LOW 8'h9a
`define ALT_OFF_CH2_HIGH 8'h9c
`define ALT_OFF_CH3_LOW 8'h9e
`define ALT_OFF_CH3_HIGH 8'ha0
`define ALT_OFF_CH4_LOW 8'ha2
`define ALT_OFF_CH4_HIGH 8'ha4
`define ALT_OFF_STEP 8'h04
`define ALT_LOW_RESET 14'h0000
`define ALT_HIGH_RESET 14'h3fff
`endif

// *** hdl/alt_pkg.sv ***
package alt_pkg;
  typedef logic [13:0] alt_field_t;
  typedef logic [15:0] alt_word_t;
  typedef logic [2:0] alt_ch_t;
endpackage

// *** hdl/alt_cmp_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface alt_cmp_if;
  logic sample_valid;
  logic [2:0] sample_ch;
  logic [15:0] sample_data;
  logic [15:0] low_limit;
  logic [15:0] high_limit;
  logic under;
  logic over;
  logic flag_valid;
  modport bank (output sample_valid, output sample_ch, output sample_data,
    output low_limit, output high_limit, input under, input over, input flag_valid);
  modport cmp (input sample_valid, input sample_ch, input sample_data,
    input low_limit, input high_limit, output under, output over, output flag_valid);
endinterface
`default_nettype wire

// *** hdl/alt_limit_cmp.sv ***
`timescale 1ns/1ps
`default_nettype none
module alt_limit_cmp
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // comparison
  alt_cmp_if.cmp cif
);
  logic under;
  logic over;
  logic valid;
  logic next_under;
  logic next_over;
  logic next_valid;

  always_comb
  begin
    next_valid = cif.sample_valid;
    next_under = cif.sample_valid && (cif.sample_data < cif.low_limit);
    next_over = cif.sample_valid && (cif.sample_data > cif.high_limit);
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      under <= 1'b0;
      over <= 1'b0;
      valid <= 1'b0;
    end
    else
    begin
      under <= next_under;
      over <= next_over;
      valid <= next_valid;
    end
  end

  assign cif.under = under;
  assign cif.over = over;
  assign cif.flag_valid = valid;

  a_under_flag: assert property (@(posedge ref_clk) disable iff (!rstn)
    cif.sample_valid && (cif.sample_data < cif.low_limit) |=> cif.under)
    else $error("under flag missing");
  a_over_flag: assert property (@(posedge ref_clk) disable iff (!rstn)
    cif.sample_valid && !(cif.sample_data > cif.high_limit) |=> !cif.over)
    else $error("over flag spurious");
endmodule // alt_limit_cmp
`default_nettype wire

// *** hdl/alt_bank.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "alt_consts.svh"
// Overview of operation
// - ch0 low limit at 0x92, bits 15:2
// - ch0 high limit at 0x94, bits 15:2
// - ch1 low limit at 0x96, bits 15:2
// - ch1 high limit at 0x98, bits 15:2
// - ch2 low limit at 0x9a, bits 15:2
// - ch2 high limit at 0x9c, bits 15:2
// - ch3 low limit at 0x9e, bits 15:2
// - ch3 high limit at 0xa0, bits 15:2
// - ch4 low limit at 0xa2, bits 15:2
// - ch4 high limit at 0xa4, bits 15:2
// - reserved low bits written zero, read zero
// - codes span 0 V to 5 V
// - field plus two zero bits compares
module alt_bank
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // register port, byte address of the word's high byte
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire alt_pkg::alt_word_t reg_wdata,
  output logic [15:0] reg_rdata,
  output logic reg_hit,
  // auxiliary samples
  input wire logic sample_valid,
  input wire alt_pkg::alt_ch_t sample_ch,
  input wire alt_pkg::alt_word_t sample_data,
  // limit flags
  output logic flag_valid,
  output alt_pkg::alt_ch_t flag_ch,
  output logic under_limit,
  output logic over_limit
);
  import alt_pkg::*;

  alt_field_t low_lim [`ALT_NUM_CH];
  alt_field_t high_lim [`ALT_NUM_CH];
  alt_field_t next_low_lim [`ALT_NUM_CH];
  alt_field_t next_high_lim [`ALT_NUM_CH];
  logic [15:0] next_rdata;
  alt_ch_t ch_q;
  alt_ch_t next_ch_q;

  alt_cmp_if cif ();

  // decode: returns {valid, is_high, channel}; pairs sit 4 bytes apart per channel
  function automatic logic [4:0] decode(input logic [7:0] a);
    logic [7:0] d;
    d = a - `ALT_OFF_CH0_LOW;
    decode = 5'h00;
    if (a >= `ALT_OFF_CH0_LOW && a <= `ALT_OFF_CH4_HIGH && d[0] == 1'b0)
      decode = {1'b1, d[1], d[4:2]};
  endfunction

  // 14 stored bits become the top of a 16-bit value, low bits zero
  function automatic alt_word_t widen(input alt_field_t f);
    widen = {f, 2'b00};
  endfunction

  logic [4:0] dec;
  assign dec = decode(reg_addr);
  assign reg_hit = dec[4];

  always_comb
  begin
    for (int i = 0; i < `ALT_NUM_CH; i++)
    begin
      next_low_lim[i] = low_lim[i];
      next_high_lim[i] = high_lim[i];
    end
    // reserved bits [1:0] dropped on write
    if (reg_wr && dec[4] && dec[2:0] < 3'd5)
    begin
      if (dec[3])
        next_high_lim[dec[2:0]] = reg_wdata[15:`ALT_FIELD_LSB];
      else
        next_low_lim[dec[2:0]] = reg_wdata[15:`ALT_FIELD_LSB];
    end
    next_rdata = reg_rdata;
    if (reg_rd)
    begin
      next_rdata = 16'h0000;
      if (dec[4] && dec[2:0] < 3'd5)
        next_rdata = dec[3] ? widen(high_lim[dec[2:0]]) : widen(low_lim[dec[2:0]]);
    end
  end

  // reset limits to 0x0000 and 0x3fff, so only samples above 0xfffc flag before the host programs them
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < `ALT_NUM_CH; i++)
      begin
        low_lim[i] <= `ALT_LOW_RESET;
        high_lim[i] <= `ALT_HIGH_RESET;
      end
      reg_rdata <= 16'h0000;
    end
    else
    begin
      for (int i = 0; i < `ALT_NUM_CH; i++)
      begin
        low_lim[i] <= next_low_lim[i];
        high_lim[i] <= next_high_lim[i];
      end
      reg_rdata <= next_rdata;
    end
  end

  // channels 5..7 carry no limits here; those samples raise no flag but still load flag_ch
  logic ch_ok;
  assign ch_ok = sample_ch < 3'd5;
  assign cif.sample_valid = sample_valid && ch_ok;
  assign cif.sample_ch = sample_ch;
  assign cif.sample_data = sample_data;
  assign cif.low_limit = ch_ok ? widen(low_lim[sample_ch]) : 16'h0000;
  assign cif.high_limit = ch_ok ? widen(high_lim[sample_ch]) : 16'hffff;

  alt_limit_cmp u_cmp
  (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .cif(cif)
  );

  always_comb
  begin
    next_ch_q = sample_valid ? sample_ch : ch_q;
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      ch_q <= 3'h0;
    else
      ch_q <= next_ch_q;
  end

  assign flag_valid = cif.flag_valid;
  assign flag_ch = ch_q;
  assign under_limit = cif.under;
  assign over_limit = cif.over;

  sequence s_write_ch0_low;
    reg_wr && reg_addr == `ALT_OFF_CH0_LOW;
  endsequence
  sequence s_read_ch0_low;
    reg_rd && reg_addr == `ALT_OFF_CH0_LOW && !reg_wr;
  endsequence

  a_ch0_low_store: assert property (@(posedge ref_clk) disable iff (!rstn)
    s_write_ch0_low ##1 s_read_ch0_low |=> reg_rdata == {$past(reg_wdata[15:2], 2), 2'b00})
    else $error("ch0 low limit not stored");
  a_ch0_high_store: assert property (@(posedge ref_clk) disable iff (!rstn)
    reg_wr && reg_addr == `ALT_OFF_CH0_HIGH |=> high_lim[0] == $past(reg_wdata[15:2]))
    else $error("ch0 high limit not stored");
  a_ch2_low_store: assert property (@(posedge ref_clk) disable iff (!rstn)
    reg_wr && reg_addr == `ALT_OFF_CH2_LOW |=> low_lim[2] == $past(reg_wdata[15:2]))
    else $error("ch2 low limit not stored");
  a_ch4_high_store: assert property (@(posedge ref_clk) disable iff (!rstn)
    reg_wr && reg_addr == `ALT_OFF_CH4_HIGH |=> high_lim[4] == $past(reg_wdata[15:2]))
    else $error("ch4 high limit not stored");
  a_rsvd_zero: assert property (@(posedge ref_clk) disable iff (!rstn)
    reg_rdata[1:0] == 2'b00)
    else $error("reserved bits read nonzero");
  a_miss_zero: assert property (@(posedge ref_clk) disable iff (!rstn)
    reg_rd && !reg_hit |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_under_out: assert property (@(posedge ref_clk) disable iff (!rstn)
    sample_valid && sample_ch == 3'd3 && sample_data < {low_lim[3], 2'b00}
      |=> under_limit && flag_ch == 3'd3)
    else $error("ch3 under not flagged");
  a_over_out: assert property (@(posedge ref_clk) disable iff (!rstn)
    sample_valid && sample_ch == 3'd1 && sample_data > {high_lim[1], 2'b00} |=> over_limit)
    else $error("ch1 over not flagged");
  a_ch1_low_store: assert property (@(posedge ref_clk) disable iff (!rstn)
    reg_wr && reg_addr == `ALT_OFF_CH1_LOW |=> low_lim[1] == $past(reg_wdata[15:2]))
    else $error("ch1 low limit not stored");
  a_ch1_high_store: assert property (@(posedge ref_clk) disable iff (!rstn)
    reg_wr && reg_addr == `ALT_OFF_CH1_HIGH |=> high_lim[1] == $past(reg_wdata[15:2]))
    else $error("ch1 high limit not stored");
  a_ch2_high_store: assert property (@(posedge ref_clk) disable iff (!rstn)
    reg_wr && reg_addr == `ALT_OFF_CH2_HIGH |=> high_lim[2] == $past(reg_wdata[15:2]))
    else $error("ch2 high limit not stored");
  a_ch3_low_store: assert property (@(posedge ref_clk) disable iff (!rstn)
    reg_wr && reg_addr == `ALT_OFF_CH3_LOW |=> low_lim[3] == $past(reg_wdata[15:2]))
    else $error("ch3 low limit not stored");
  a_ch3_high_store: assert property (@(posedge ref_clk) disable iff (!rstn)
    reg_wr && reg_addr == `ALT_OFF_CH3_HIGH |=> high_lim[3] == $past(reg_wdata[15:2]))
    else $error("ch3 high limit not stored");
  a_ch4_low_store: assert property (@(posedge ref_clk) disable iff (!rstn)
    reg_wr && reg_addr == `ALT_OFF_CH4_LOW |=> low_lim[4] == $past(reg_wdata[15:2]))
    else $error("ch4 low limit not stored");
  a_ch0_low_read: assert property (@(posedge ref_clk) disable iff (!rstn)
    reg_rd && reg_addr == `ALT_OFF_CH0_LOW |=> reg_rdata == {$past(low_lim[0]), 2'b00})
    else $error("ch0 low limit read back wrong");
  a_ch0_high_read: assert property (@(posedge ref_clk) disable iff (!rstn)
    reg_rd && reg_addr == `ALT_OFF_CH0_HIGH |=> reg_rdata == {$past(high_lim[0]), 2'b00})
    else $error("ch0 high limit read back wrong");
  a_ch1_low_read: assert property (@(posedge ref_clk) disable iff (!rstn)
    reg_rd && reg_addr == `ALT_OFF_CH1_LOW |=> reg_rdata == {$past(low_lim[1]), 2'b00})
    else $error("ch1 low limit read back wrong");
  a_ch1_high_read: assert property (@(posedge ref_clk) disable iff (!rstn)
    reg_rd && reg_addr == `ALT_OFF_CH1_HIGH |=> reg_rdata == {$past(high_lim[1]), 2'b00})
    else $error("ch1 high limit read back wrong");
  a_ch2_low_read: assert property (@(posedge ref_clk) disable iff (!rstn)
    reg_rd && reg_addr == `ALT_OFF_CH2_LOW |=> reg_rdata == {$past(low_lim[2]), 2'b00})
    else $error("ch2 low limit read back wrong");
  a_ch2_high_read: assert property (@(posedge ref_clk) disable iff (!rstn)
    reg_rd && reg_addr == `ALT_OFF_CH2_HIGH |=> reg_rdata == {$past(high_lim[2]), 2'b00})
    else $error("ch2 high limit read back wrong");
  a_ch3_low_read: assert property (@(posedge ref_clk) disable iff (!rstn)
    reg_rd && reg_addr == `ALT_OFF_CH3_LOW |=> reg_rdata == {$past(low_lim[3]), 2'b00})
    else $error("ch3 low limit read back wrong");
  a_ch3_high_read: assert property (@(posedge ref_clk) disable iff (!rstn)
    reg_rd && reg_addr == `ALT_OFF_CH3_HIGH |=> reg_rdata == {$past(high_lim[3]), 2'b00})
    else $error("ch3 high limit read back wrong");
  a_ch4_low_read: assert property (@(posedge ref_clk) disable iff (!rstn)
    reg_rd && reg_addr == `ALT_OFF_CH4_LOW |=> reg_rdata == {$past(low_lim[4]), 2'b00})
    else $error("ch4 low limit read back wrong");
  a_ch4_high_read: assert property (@(posedge ref_clk) disable iff (!rstn)
    reg_rd && reg_addr == `ALT_OFF_CH4_HIGH |=> reg_rdata == {$past(high_lim[4]), 2'b00})
    else $error("ch4 high limit read back wrong");
  a_ch0_under_out: assert property (@(posedge ref_clk) disable iff (!rstn)
    sample_valid && sample_ch == 3'h0 && sample_data < {low_lim[0], 2'b00}
      |=> under_limit && flag_ch == 3'h0)
    else $error("ch0 under not flagged");
  a_ch1_under_out: assert property (@(posedge ref_clk) disable iff (!rstn)
    sample_valid && sample_ch == 3'h1 && sample_data < {low_lim[1], 2'b00}
      |=> under_limit && flag_ch == 3'h1)
    else $error("ch1 under not flagged");
  a_ch2_under_out: assert property (@(posedge ref_clk) disable iff (!rstn)
    sample_valid && sample_ch == 3'h2 && sample_data < {low_lim[2], 2'b00}
      |=> under_limit && flag_ch == 3'h2)
    else $error("ch2 under not flagged");
  a_ch4_under_out: assert property (@(posedge ref_clk) disable iff (!rstn)
    sample_valid && sample_ch == 3'h4 && sample_data < {low_lim[4], 2'b00}
      |=> under_limit && flag_ch == 3'h4)
    else $error("ch4 under not flagged");
  a_ch0_over_out: assert property (@(posedge ref_clk) disable iff (!rstn)
    sample_valid && sample_ch == 3'h0 && sample_data > {high_lim[0], 2'b00}
      |=> over_limit && flag_ch == 3'h0)
    else $error("ch0 over not flagged");
  a_ch2_over_out: assert property (@(posedge ref_clk) disable iff (!rstn)
    sample_valid && sample_ch == 3'h2 && sample_data > {high_lim[2], 2'b00}
      |=> over_limit && flag_ch == 3'h2)
    else $error("ch2 over not flagged");
  a_ch3_over_out: assert property (@(posedge ref_clk) disable iff (!rstn)
    sample_valid && sample_ch == 3'h3 && sample_data > {high_lim[3], 2'b00}
      |=> over_limit && flag_ch == 3'h3)
    else $error("ch3 over not flagged");
  a_ch4_over_out: assert property (@(posedge ref_clk) disable iff (!rstn)
    sample_valid && sample_ch == 3'h4 && sample_data > {high_lim[4], 2'b00}
      |=> over_limit && flag_ch == 3'h4)
    else $error("ch4 over not flagged");
  a_ch0_no_under: assert property (@(posedge ref_clk) disable iff (!rstn)
    sample_valid && sample_ch == 3'h0 && sample_data >= {low_lim[0], 2'b00}
      |=> !under_limit)
    else $error("ch0 under flagged in range");
  a_ch1_no_under: assert property (@(posedge ref_clk) disable iff (!rstn)
    sample_valid && sample_ch == 3'h1 && sample_data >= {low_lim[1], 2'b00}
      |=> !under_limit)
    else $error("ch1 under flagged in range");
  a_ch2_no_under: assert property (@(posedge ref_clk) disable iff (!rstn)
    sample_valid && sample_ch == 3'h2 && sample_data >= {low_lim[2], 2'b00}
      |=> !under_limit)
    else $error("ch2 under flagged in range");
  a_ch3_no_under: assert property (@(posedge ref_clk) disable iff (!rstn)
    sample_valid && sample_ch == 3'h3 && sample_data >= {low_lim[3], 2'b00}
      |=> !under_limit)
    else $error("ch3 under flagged in range");
  a_ch4_no_under: assert property (@(posedge ref_clk) disable iff (!rstn)
    sample_valid && sample_ch == 3'h4 && sample_data >= {low_lim[4], 2'b00}
      |=> !under_limit)
    else $error("ch4 under flagged in range");
  a_ch0_no_over: assert property (@(posedge ref_clk) disable iff (!rstn)
    sample_valid && sample_ch == 3'h0 && sample_data <= {high_lim[0], 2'b00}
      |=> !over_limit)
    else $error("ch0 over flagged in range");
  a_ch1_no_over: assert property (@(posedge ref_clk) disable iff (!rstn)
    sample_valid && sample_ch == 3'h1 && sample_data <= {high_lim[1], 2'b00}
      |=> !over_limit)
    else $error("ch1 over flagged in range");
  a_ch2_no_over: assert property (@(posedge ref_clk) disable iff (!rstn)
    sample_valid && sample_ch == 3'h2 && sample_data <= {high_lim[2], 2'b00}
      |=> !over_limit)
    else $error("ch2 over flagged in range");
  a_ch3_no_over: assert property (@(posedge ref_clk) disable iff (!rstn)
    sample_valid && sample_ch == 3'h3 && sample_data <= {high_lim[3], 2'b00}
      |=> !over_limit)
    else $error("ch3 over flagged in range");
  a_ch4_no_over: assert property (@(posedge ref_clk) disable iff (!rstn)
    sample_valid && sample_ch == 3'h4 && sample_data <= {high_lim[4], 2'b00}
      |=> !over_limit)
    else $error("ch4 over flagged in range");
  a_high_ch_quiet: assert property (@(posedge ref_clk) disable iff (!rstn)
    sample_valid && sample_ch > 3'h4 |=> !flag_valid && !under_limit && !over_limit)
    else $error("flag raised for channel without limits");
endmodule // alt_bank
`default_nettype wire

// *** verif/alt_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module alt_host
(
  // clock
  input wire logic ref_clk,
  // register port
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [15:0] reg_wdata
);
  initial
  begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
  end
  // entered at a falling edge; a read may follow in the very next cycle
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = {d[15:2], 2'b00};
    @(negedge ref_clk);
    reg_wr = 1'b0;
    reg_wdata = ~reg_wdata;
  endtask
  task automatic rd(input logic [7:0] a);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge ref_clk);
    reg_rd = 1'b0;
    @(negedge ref_clk);
  endtask
endmodule // alt_host
`default_nettype wire

// *** verif/aux_limit_threshold_bank_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module aux_limit_threshold_bank_tb;
  import alt_pkg::*;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic sample_valid = 1'b0;
  alt_ch_t sample_ch = 3'h0;
  alt_word_t sample_data = 16'h0000;
  logic reg_wr, reg_rd, reg_hit, flag_valid, under_limit, over_limit;
  logic [7:0] reg_addr;
  alt_word_t reg_wdata;
  logic [15:0] reg_rdata;
  alt_ch_t flag_ch;
  logic [15:0] lim [10];
  logic [15:0] b [6];
  logic [7:0] bad [4] = '{8'h90, 8'h93, 8'ha6, 8'h95};
  logic [31:0] seed = 32'h0b9f;
  int n_fail = 0;
  int cmp_count = 0;
  int cyc = 0;
  int ri;
  always #12.5 ref_clk = ~ref_clk;
  alt_host i_alt_host (.ref_clk(ref_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata));
  alt_bank i_alt_bank (.ref_clk(ref_clk), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
    .sample_valid(sample_valid), .sample_ch(sample_ch), .sample_data(sample_data),
    .flag_valid(flag_valid), .flag_ch(flag_ch), .under_limit(under_limit),
    .over_limit(over_limit));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // stored word with zero low bits is the comparison value
  function automatic logic [5:0] exp_flag(input int c, input logic [15:0] d);
    if (c > 4)
      return 6'h00;
    return {1'b1, 3'(c), d < lim[2 * c], d > lim[2 * c + 1]};
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_flag(input logic [5:0] got, input logic [5:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rdall();
    for (int i = 0; i < 10; i++)
    begin
      i_alt_host.rd(8'h92 + 8'(2 * i));
      chk(reg_rdata, lim[i]);
      chk(16'(reg_hit), 16'h0001);
    end
  endtask
  task automatic smp(input int c, input logic [15:0] d);
    sample_valid = 1'b1;
    sample_ch = 3'(c);
    sample_data = d;
    @(negedge ref_clk);
    sample_valid = 1'b0;
    sample_data = ~d;
    chk_flag({flag_valid, flag_ch & {3{flag_valid}}, under_limit, over_limit},
      exp_flag(c, d));
    @(negedge ref_clk);
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_fail++;
      tally_and_finish();
    end
  end
  initial
  begin
    repeat (12) @(negedge ref_clk);
    rstn = 1'b1;
    for (int i = 0; i < 10; i++)
      lim[i] = i[0] ? 16'hfffc : 16'h0000;
    rdall();
    $display("test reset values done");
    for (int k = 0; k < 60; k++)
    begin
      ri = int'(xs() % 10);
      lim[ri] = 16'(xs()) & 16'hfffc;
      i_alt_host.wr(8'h92 + 8'(2 * ri), lim[ri] | 16'(k[1:0]));
      i_alt_host.rd(8'h92 + 8'(2 * ri));
      chk(reg_rdata, lim[ri]);
      smp(ri / 2, 16'(xs()));
      smp(int'(xs() % 8), 16'(xs()));
    end
    $display("test random writes done");
    // edges of each window, both ends of the scale, and channels without limits
    for (int c = 0; c < 8; c++)
    begin
      ri = 2 * (c % 5);
      b = '{lim[ri] - 16'h1, lim[ri], lim[ri + 1], lim[ri + 1] + 16'h1, 16'h0000, 16'hffff};
      foreach (b[j])
        smp(c, b[j]);
    end
    $display("test limit edges done");
    foreach (bad[j])
    begin
      i_alt_host.wr(bad[j], 16'(xs()));
      i_alt_host.rd(bad[j]);
      chk(reg_rdata, 16'h0000);
      chk(16'(reg_hit), 16'h0000);
    end
    rdall();
    $display("test unmapped addresses done");
    tally_and_finish();
  end
endmodule // aux_limit_threshold_bank_tb
`default_nettype wire
